// ===== serial_adc_pkg.sv
// Shared constants and types for the serial converter link.
// Assumes one 50 MHz system clock on both ends of the link.
package serial_adc_pkg;

  // ****************************************
  // Clock and link timing
  // ****************************************
  function automatic int ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  localparam int CLK_PERIOD_NS     = 20;
  localparam int SCLK_MIN_PERIOD_NS = 100;
  localparam int SCLK_HALF_MIN_CYC = ceil_div(SCLK_MIN_PERIOD_NS, 2 * CLK_PERIOD_NS);
  // Round trip through both synchronisers needs four cycles per half period
  localparam int SCLK_HALF_SYNC_CYC = 4;
  localparam int SCLK_HALF_CYC     = (SCLK_HALF_MIN_CYC < SCLK_HALF_SYNC_CYC) ?
                                     SCLK_HALF_SYNC_CYC : SCLK_HALF_MIN_CYC;
  localparam int T_QUIET_NS        = 50;
  localparam int QUIET_CYC         = ceil_div(T_QUIET_NS, CLK_PERIOD_NS);
  localparam int FRAME_PERIODS     = 20;
  localparam int FRAME_EDGES       = 16;
  localparam int PAD_PERIODS_CYC   = (FRAME_PERIODS - FRAME_EDGES) * 2 * SCLK_HALF_CYC;
  localparam int GAP_CYC           = (PAD_PERIODS_CYC < QUIET_CYC) ? QUIET_CYC : PAD_PERIODS_CYC;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int CNT_W       = 5;
  localparam int TIMER_W     = 8;
  localparam int LEAD_ZEROS  = 3;
  localparam int DATA_BITS   = 8;
  localparam int TRAIL_ZEROS = 4;
  localparam int WORD_BITS   = LEAD_ZEROS + DATA_BITS + TRAIL_ZEROS;
  localparam int RX_DATA_LSB = 4;

  localparam logic [CNT_W-1:0]   EDGE_LAST     = 5'h10;
  localparam logic [CNT_W-1:0]   EDGE_KEEP     = 5'h02;
  localparam logic [CNT_W-1:0]   EDGE_NORMAL   = 5'h0A;
  localparam logic [TIMER_W-1:0] HALF_LOAD     = TIMER_W'(SCLK_HALF_CYC - 1);
  localparam logic [TIMER_W-1:0] GAP_LOAD      = TIMER_W'(GAP_CYC - 1);

  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b01,
    MODE_NORMAL   = 2'b10
  } power_mode_t;

endpackage

// ===== serial_adc_if.sv
// Link between host serial master and converter serial logic.
// The data wire is pulled high while the converter does not drive it.
interface serial_adc_if;
  logic frameSelN;        // Frame select, active low
  logic serialClock;      // Serial clock from the host
  logic serialResultOut;  // Converter data output value
  logic serialResultOe;   // Converter drives the data wire
  logic dataLine;         // Resolved data wire level

  assign dataLine = serialResultOe ? serialResultOut : 1'b1;

  modport device (
    input  frameSelN,
    input  serialClock,
    output serialResultOut,
    output serialResultOe
  );

  modport host (
    output frameSelN,
    output serialClock,
    input  dataLine
  );
endinterface

// ===== serial_adc_device.sv
// Converter end: serial frame counting, output shifting and power modes.
// Assumes frame select and serial clock come from another clock domain.
module serial_adc_device (
  input  wire logic                       clock,       // System clock
  input  wire logic                       nrst,        // Async reset, active low
  serial_adc_if.device                    link,        // Serial link pins
  input  wire logic [7:0]                 sampleIn,    // Value to convert
  output logic                            normalMode,  // High in normal mode
  output logic                            powerPending,// Next result unusable
  output logic                            frameDone,   // Full word sent, pulse
  output logic                            frameAbort,  // Frame cut short, pulse
  output logic                            frameDummy   // Done word was a dummy
);
  import serial_adc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]           csSync;
    logic [1:0]           sclkSync;
    logic                 csPrev;
    logic                 sclkPrev;
    logic [CNT_W-1:0]     edgeCount;
    power_mode_t          mode;
    power_mode_t          frameMode;
    logic                 wakeFrame;
    logic                 pending;
    logic [WORD_BITS-1:0] shiftOut;
    logic                 dataOut;
    logic                 dataOe;
    logic                 done;
    logic                 abort;
    logic                 dummy;
  } dev_state_t;

  localparam dev_state_t RESET_STATE = '{
    csSync:    2'h3,
    sclkSync:  2'h3,
    csPrev:    1'b1,
    sclkPrev:  1'b1,
    edgeCount: '0,
    mode:      MODE_SHUTDOWN,
    frameMode: MODE_SHUTDOWN,
    wakeFrame: 1'b0,
    pending:   1'b1,
    shiftOut:  '0,
    dataOut:   1'b0,
    dataOe:    1'b0,
    done:      1'b0,
    abort:     1'b0,
    dummy:     1'b0
  };

  dev_state_t state;
  dev_state_t next_state;

  // ****************************************
  // Helpers
  // ****************************************
  // Level went from high to low between two samples
  function automatic logic fell(input logic earlier, input logic later);
    return earlier & ~later;
  endfunction

  // Level went from low to high between two samples
  function automatic logic rose(input logic earlier, input logic later);
    return ~earlier & later;
  endfunction

  // Word of a frame that wakes the converter, or follows a cut wake, is unusable
  function automatic logic wake_in_progress(input dev_state_t s);
    return (s.mode == MODE_SHUTDOWN) | s.pending;
  endfunction

  // Word shifted out after select falls: leading zeros, sample, trailing zeros
  function automatic logic [WORD_BITS-1:0] frame_word(input logic [DATA_BITS-1:0] sample);
    return {LEAD_ZEROS'(0), sample, TRAIL_ZEROS'(0)};
  endfunction

  // Power mode left by a select rise that cuts a frame after count falls
  function automatic power_mode_t mode_after_cut(input logic [CNT_W-1:0] count,
                                                 input power_mode_t  earlierMode);
    if (count < EDGE_KEEP) begin
      return earlierMode;
    end else if (count < EDGE_NORMAL) begin
      return MODE_SHUTDOWN;
    end
    return MODE_NORMAL;
  endfunction

  logic csFall;
  logic csRise;
  logic sclkFall;

  // ****************************************
  // Edge detection on synchronised pins
  // ****************************************
  assign csFall   = fell(state.csPrev, state.csSync[1]);
  assign csRise   = rose(state.csPrev, state.csSync[1]);
  // Falls while select is high belong to no frame
  assign sclkFall = fell(state.sclkPrev, state.sclkSync[1]) & ~state.csSync[1];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state          = state;
    next_state.csSync   = {state.csSync[0], link.frameSelN};
    next_state.sclkSync = {state.sclkSync[0], link.serialClock};
    next_state.csPrev   = state.csSync[1];
    next_state.sclkPrev = state.sclkSync[1];
    next_state.done     = 1'b0;
    next_state.abort    = 1'b0;

    if (csFall) begin
      next_state.frameMode = state.mode;
      next_state.mode      = MODE_NORMAL;
      next_state.wakeFrame = wake_in_progress(state);
      next_state.pending   = wake_in_progress(state);
      next_state.edgeCount = '0;
      next_state.shiftOut  = frame_word(sampleIn);
      next_state.dataOut   = 1'b0;
      next_state.dataOe    = 1'b1;
    end else if (csRise) begin
      // Select rise wins over a serial clock fall in the same cycle
      // Float on select rise
      next_state.dataOe    = 1'b0;
      next_state.dataOut   = 1'b0;
      next_state.edgeCount = '0;
      if (state.edgeCount < EDGE_LAST) begin
        next_state.abort = 1'b1;
        next_state.mode  = mode_after_cut(state.edgeCount, state.frameMode);
        if (mode_after_cut(state.edgeCount, state.frameMode) == MODE_SHUTDOWN) begin
          next_state.pending = 1'b1;
        end
      end
    end else if (sclkFall && (state.edgeCount < EDGE_LAST)) begin
      next_state.edgeCount = state.edgeCount + CNT_W'(1);
      if (state.edgeCount == EDGE_LAST - CNT_W'(1)) begin
        next_state.dataOe  = 1'b0;
        next_state.dataOut = 1'b0;
        next_state.done    = 1'b1;
        next_state.dummy   = state.wakeFrame;
        next_state.pending = 1'b0;
      end else begin
        next_state.dataOut  = state.shiftOut[WORD_BITS-1];
        next_state.shiftOut = {state.shiftOut[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.serialResultOut = state.dataOut;
  assign link.serialResultOe  = state.dataOe;
  assign normalMode           = (state.mode == MODE_NORMAL);
  assign powerPending         = state.pending;
  assign frameDone            = state.done;
  assign frameAbort           = state.abort;
  assign frameDummy           = state.dummy;

endmodule

// ===== serial_adc_host.sv
// Host end: generates frame select and serial clock, gathers the word.
// Assumes the data wire comes from another domain and is synchronised.
module serial_adc_host (
  input  wire logic                 clock,        // System clock
  input  wire logic                 nrst,         // Async reset, active low
  serial_adc_if.host                link,         // Serial link pins
  input  wire logic                 startReq,     // Start a frame
  input  wire logic [4:0]           frameEdges,   // Falling edges, 0..16
  input  wire logic                 idleLow,      // Keep select low after full word
  output logic                      ready,        // Request can be taken
  output logic [7:0]                resultWord,   // Last full result
  output logic                      resultStrobe, // Result valid, pulse
  output logic                      resultDummy   // Result was a dummy
);
  import serial_adc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [5:0] {
    HS_IDLE   = 6'b000001,
    HS_SELECT = 6'b000010,
    HS_CLKLO  = 6'b000100,
    HS_CLKHI  = 6'b001000,
    HS_HOLD   = 6'b010000,
    HS_GAP    = 6'b100000
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t              fsm;
    logic                   csN;
    logic                   sclk;
    logic [1:0]             dataSync;
    logic [TIMER_W-1:0]     timer;
    logic [CNT_W-1:0]       edgeCount;
    logic [CNT_W-1:0]       target;
    logic                   holdLow;
    logic                   pending;
    logic                   needDummy;
    logic                   frameDummy;
    logic [FRAME_EDGES-1:0] rx;
    logic [7:0]             word;
    logic                   strobe;
    logic                   dummy;
  } host_state_t;

  host_state_t state;
  host_state_t next_state;
  logic        launch;
  logic        finish;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state          = state;
    next_state.dataSync = {state.dataSync[0], link.dataLine};
    next_state.strobe   = 1'b0;
    launch              = 1'b0;
    finish              = 1'b0;
    if (state.timer != '0) begin
      next_state.timer = state.timer - TIMER_W'(1);
    end
    unique case (state.fsm)
      HS_IDLE: begin
        if (startReq) begin
          launch = 1'b1;
        end
      end
      HS_HOLD: begin
        if (startReq) begin
          next_state.target  = (frameEdges > EDGE_LAST) ? EDGE_LAST : frameEdges;
          next_state.holdLow = idleLow;
          next_state.pending = 1'b1;
          next_state.csN     = 1'b1;
          next_state.timer   = GAP_LOAD;
          next_state.fsm     = HS_GAP;
        end
      end
      HS_SELECT: begin
        if (state.timer == '0) begin
          if (state.target == '0) begin
            finish = 1'b1;
          end else begin
            next_state.sclk      = 1'b0;
            next_state.edgeCount = CNT_W'(1);
            next_state.rx        = {state.rx[FRAME_EDGES-2:0], state.dataSync[1]};
            next_state.timer     = HALF_LOAD;
            next_state.fsm       = HS_CLKLO;
          end
        end
      end
      HS_CLKLO: begin
        if (state.timer == '0) begin
          if (state.edgeCount == state.target) begin
            finish = 1'b1;
          end else begin
            next_state.sclk  = 1'b1;
            next_state.timer = HALF_LOAD;
            next_state.fsm   = HS_CLKHI;
          end
        end
      end
      HS_CLKHI: begin
        if (state.timer == '0) begin
          next_state.sclk      = 1'b0;
          next_state.edgeCount = state.edgeCount + CNT_W'(1);
          next_state.rx        = {state.rx[FRAME_EDGES-2:0], state.dataSync[1]};
          next_state.timer     = HALF_LOAD;
          next_state.fsm       = HS_CLKLO;
        end
      end
      HS_GAP: begin
        if (state.timer == '0) begin
          if (state.pending) begin
            launch = 1'b1;
          end else begin
            next_state.fsm = HS_IDLE;
          end
        end
      end
    endcase

    if (launch) begin
      if (!state.pending) begin
        next_state.target  = (frameEdges > EDGE_LAST) ? EDGE_LAST : frameEdges;
        next_state.holdLow = idleLow;
      end
      next_state.pending    = 1'b0;
      next_state.frameDummy = state.needDummy;
      next_state.csN        = 1'b0;
      next_state.edgeCount  = '0;
      next_state.timer      = HALF_LOAD;
      next_state.fsm        = HS_SELECT;
    end

    if (finish) begin
      next_state.sclk = 1'b1;
      if (state.edgeCount == EDGE_LAST) begin
        next_state.needDummy = 1'b0;
        next_state.strobe    = 1'b1;
        next_state.dummy     = state.frameDummy;
        next_state.word      = state.rx[RX_DATA_LSB+DATA_BITS-1:RX_DATA_LSB];
      end else if ((state.edgeCount >= EDGE_KEEP) && (state.edgeCount < EDGE_NORMAL)) begin
        next_state.needDummy = 1'b1;
      end
      if ((state.edgeCount == EDGE_LAST) && state.holdLow) begin
        next_state.fsm = HS_HOLD;
      end else begin
        next_state.csN   = 1'b1;
        next_state.timer = GAP_LOAD;
        next_state.fsm   = HS_GAP;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '{fsm: HS_IDLE, csN: 1'b1, sclk: 1'b1, dataSync: 2'h3, needDummy: 1'b1, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Clock half period from synchroniser need, which exceeds limit
  assign link.serialClock = state.sclk;
  assign link.frameSelN   = state.csN;
  assign ready            = (state.fsm == HS_IDLE) | (state.fsm == HS_HOLD);
  assign resultWord       = state.word;
  assign resultStrobe     = state.strobe;
  assign resultDummy      = state.dummy;

endmodule

// ===== serial_adc_checker.sv
// Concurrent checks on the serial link between host and converter ends.
// Assumes both ends share clock and nrst; placed beside the link interface.
module serial_adc_checker (
  input wire logic clock,           // System clock
  input wire logic nrst,            // Async reset, active low
  input wire logic frameSelN,       // Frame select, active low
  input wire logic serialClock,     // Serial clock
  input wire logic serialResultOut, // Converter data value
  input wire logic serialResultOe,  // Converter drives data
  input wire logic dataLine         // Resolved data wire
);
  timeunit 1ns;
  timeprecision 100ps;
  import serial_adc_pkg::*;

  // ****************************************
  // Serial clock falls counted per frame
  // ****************************************
  logic       sclkPrev;
  logic [4:0] fallCount;
  logic       sclkFall;

  assign sclkFall = sclkPrev && !serialClock;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclkPrev  <= 1'b1;
      fallCount <= 5'h00;
    end else begin
      sclkPrev <= serialClock;
      if (frameSelN) begin
        fallCount <= 5'h00;
      end else if (sclkFall && fallCount < 5'h10) begin
        fallCount <= fallCount + 5'h01;
      end
    end
  end

  // ****************************************
  // Link properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_oe_on_select: assert property (
    $fell(frameSelN) |-> ##[1:4] (serialResultOe && !serialResultOut))
    else $error("data not driven after select fall");
  chk_float_on_rise: assert property (
    $rose(frameSelN) |-> ##[1:4] !serialResultOe)
    else $error("data not released after select rise");
  chk_float_after_last: assert property (
    (sclkFall && !frameSelN && fallCount == 5'h0F) |-> ##[1:4] !serialResultOe)
    else $error("data not released after last fall");
  chk_lead_zeros: assert property (
    (serialResultOe && !frameSelN && fallCount <= 5'h03) |-> !dataLine)
    else $error("leading bit not zero");
  chk_trail_zeros: assert property (
    (serialResultOe && !frameSelN && fallCount >= 5'h0D) |-> !dataLine)
    else $error("trailing bit not zero");
  chk_quiet_gap: assert property (
    $rose(frameSelN) |=> frameSelN[*3])
    else $error("select low again too soon");
  chk_sclk_half: assert property (
    $changed(serialClock) |=> $stable(serialClock)[*2])
    else $error("serial clock level too short");
  chk_word_length: assert property (
    (!frameSelN && fallCount == 5'h10) |-> !sclkFall)
    else $error("serial clock fall past word end");
endmodule

// ===== serial_adc_mode_control_tb_top.sv
// Bench joining the host and converter ends over the serial link.
// Assumes one shared clock and reset; checks modes, flags and results.
module serial_adc_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_adc_pkg::*;

  typedef struct {
    logic [4:0] edges;
    logic       idle;
    logic [7:0] sample;
    logic       normal;
    logic       pending;
    logic       dummy;
  } step_t;

  // Edges, idle low, sample, then expected mode, pending and dummy flags
  step_t steps [11] = '{
    '{5'h10, 1'b0, 8'h5A, 1'b1, 1'b0, 1'b1}, '{5'h10, 1'b0, 8'hA5, 1'b1, 1'b0, 1'b0},
    '{5'h01, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0}, '{5'h0C, 1'b0, 8'hFF, 1'b1, 1'b0, 1'b0},
    '{5'h05, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0}, '{5'h00, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
    '{5'h09, 1'b0, 8'hFF, 1'b0, 1'b1, 1'b0}, '{5'h0A, 1'b0, 8'hFF, 1'b1, 1'b1, 1'b0},
    '{5'h10, 1'b1, 8'h3C, 1'b1, 1'b0, 1'b1}, '{5'h10, 1'b0, 8'hC3, 1'b1, 1'b0, 1'b0},
    '{5'h10, 1'b0, 8'h81, 1'b1, 1'b0, 1'b0}};

  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       startReq = 1'b0;
  logic [4:0] frameEdges = 5'h10;
  logic       idleLow = 1'b0;
  logic [7:0] sampleIn = 8'h00;
  logic       normalMode, powerPending, frameDone, frameAbort, frameDummy;
  logic       ready, resultStrobe, resultDummy;
  logic [7:0] resultWord;
  logic       doneSeen = 1'b0;
  logic       abortSeen = 1'b0;
  logic       strobeSeen = 1'b0;
  int         mismatches = 0;
  int         testsRun = 0;
  int         cycles = 0;

  always #10 clock = ~clock;

  serial_adc_if serial_adc_if_i ();

  serial_adc_device serial_adc_device_i (.clock(clock), .nrst(nrst), .link(serial_adc_if_i.device),
    .sampleIn(sampleIn), .normalMode(normalMode), .powerPending(powerPending), .frameDone(frameDone),
    .frameAbort(frameAbort), .frameDummy(frameDummy));

  serial_adc_host serial_adc_host_i (.clock(clock), .nrst(nrst), .link(serial_adc_if_i.host),
    .startReq(startReq), .frameEdges(frameEdges), .idleLow(idleLow), .ready(ready),
    .resultWord(resultWord), .resultStrobe(resultStrobe), .resultDummy(resultDummy));

  serial_adc_checker serial_adc_checker_i (.clock(clock), .nrst(nrst),
    .frameSelN(serial_adc_if_i.frameSelN), .serialClock(serial_adc_if_i.serialClock),
    .serialResultOut(serial_adc_if_i.serialResultOut), .serialResultOe(serial_adc_if_i.serialResultOe),
    .dataLine(serial_adc_if_i.dataLine));

  // ****************************************
  // Pulse capture and run limit
  // ****************************************
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (frameDone === 1'b1) doneSeen <= 1'b1;
    if (frameAbort === 1'b1) abortSeen <= 1'b1;
    if (resultStrobe === 1'b1) strobeSeen <= 1'b1;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    testsRun++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(8'(ready), 8'h01);
  endtask

  // One host frame; waits six cycles after ready so pulses that land with it are captured
  task automatic run_frame(input step_t s);
    wait_ready();
    sampleIn = s.sample;
    frameEdges = s.edges;
    idleLow = s.idle;
    doneSeen = 1'b0;
    abortSeen = 1'b0;
    strobeSeen = 1'b0;
    startReq = 1'b1;
    @(posedge clock);
    #1;
    startReq = 1'b0;
    wait_ready();
    repeat (6) @(posedge clock);
    #1;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    check(8'(normalMode), 8'h00);
    check(8'(powerPending), 8'h01);
    repeat (5) @(posedge clock);
    #1;
    foreach (steps[i]) begin
      run_frame(steps[i]);
      check(8'(normalMode), 8'(steps[i].normal));
      check(8'(powerPending), 8'(steps[i].pending));
      check(8'(doneSeen), 8'(steps[i].edges == 5'h10));
      check(8'(strobeSeen), 8'(steps[i].edges == 5'h10));
      if (steps[i].edges >= 5'h02) check(8'(abortSeen), 8'(steps[i].edges != 5'h10));
      if (steps[i].edges == 5'h10) begin
        check(8'(frameDummy), 8'(steps[i].dummy));
        check(8'(resultDummy), 8'(steps[i].dummy));
        if (!steps[i].dummy) check(resultWord, steps[i].sample);
      end
    end
    conclude();
  end
endmodule
